// [src/ifpc_pkg.sv]
// Constants, register indices and field layouts for the flash programming controller.
// Assumes one 250 MHz system clock and a byte-wide CPU register port.
//
// Notes on behaviour
// [RULE_01] Address high holds bits 13..8, top two zero
// [RULE_02] First data low write only stores itself
// [RULE_03] First data high loads buffer, bumps address
// [RULE_04] Enabled bit: software may clear, never set
// [RULE_05] Enabled bit high means erase/write allowed
// [RULE_06] Mode codes: write, erase, read, unlock
// [RULE_07] Software unlocks before any erase or write
// [RULE_08] Trigger starts timer; cleared at timeout
// [RULE_09] Software writes unlock patterns before timeout
// [RULE_10] Fixed six-byte unlock pattern; mismatch stays locked
// [RULE_11] Write-initiate runs erase/write, halts CPU, self-clears
// [RULE_12] Erase or write lasts about 2.2 ms
// [RULE_13] Reads need read-enable bit high
// [RULE_14] Read-initiate reads one word, halts, self-clears
// [RULE_15] Software never sets three start bits together
// [RULE_16] Software ensures slow clock stable first
// [RULE_17] Software waits for operation end first
// [RULE_18] Writing 55H to reset pattern resets chip
// [RULE_19] Buffer-clear bit clears buffer then self-clears
// [RULE_20] Buffer address stops at word 63
// [RULE_21] Buffer cleared after each write process
// [RULE_22] Software blank-checks page after erase
// [RULE_23] Software verifies write, clears buffer, retries
// [RULE_24] Software clears enabled bit when finished
// [RULE_25] Locked device ignores erase/write initiate
// [RULE_26] Page erase ignores address bits 5..0
package ifpc_pkg;
  // Sizes
  localparam int ADDR_W = 14;
  localparam int DATA_W = 16;
  localparam int PAGE_W = 6;
  localparam int BUF_WORDS = 64;
  localparam logic [PAGE_W-1:0] PAGE_LAST = 6'h3f;
  // Register indices on the byte port
  localparam logic [3:0] IDX_ADDR_LOW = 4'h0;
  localparam logic [3:0] IDX_ADDR_HIGH = 4'h1;
  localparam logic [3:0] IDX_D0_LOW = 4'h2;
  localparam logic [3:0] IDX_D0_HIGH = 4'h3;
  localparam logic [3:0] IDX_D1_LOW = 4'h4;
  localparam logic [3:0] IDX_D1_HIGH = 4'h5;
  localparam logic [3:0] IDX_D2_LOW = 4'h6;
  localparam logic [3:0] IDX_D2_HIGH = 4'h7;
  localparam logic [3:0] IDX_D3_LOW = 4'h8;
  localparam logic [3:0] IDX_D3_HIGH = 4'h9;
  localparam logic [3:0] IDX_CTRL = 4'ha;
  localparam logic [3:0] IDX_RST_PAT = 4'hb;
  localparam logic [3:0] IDX_BUF_CLR = 4'hc;
  // Field positions
  localparam int ADDR_HIGH_LSB = 8;
  localparam int BUF_CLR_BIT = 0;
  // Reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 14'h0000;
  localparam logic [DATA_W-1:0] WORD_RESET = 16'h0000;
  // Mode codes
  localparam logic [2:0] MODE_WRITE = 3'h0;
  localparam logic [2:0] MODE_ERASE = 3'h1;
  localparam logic [2:0] MODE_READ = 3'h3;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;
  // Unlock pattern, second to fourth pairs
  localparam logic [DATA_W-1:0] UNLOCK_WORD1 = 16'h0400;
  localparam logic [DATA_W-1:0] UNLOCK_WORD2 = 16'h090d;
  localparam logic [DATA_W-1:0] UNLOCK_WORD3 = 16'h40c3;
  // Chip reset key
  localparam logic [7:0] CHIP_RESET_KEY = 8'h55;
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int PROG_TIME_NS = 2_200_000;
  localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int UNLOCK_TIME_NS = 1000;
  localparam int UNLOCK_CYCLES = UNLOCK_TIME_NS / CLK_PERIOD_NS;
  localparam int READ_TIME_NS = 16;
  localparam int READ_CYCLES = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Control/status byte layout
  typedef struct packed {
    logic enabled;
    logic [2:0] mode;
    logic trigger;
    logic wrInit;
    logic rdEnable;
    logic rdInit;
  } ifpc_ctrl_t;
endpackage : ifpc_pkg

// [src/ifpc_top.sv]
// Flash program controller: byte registers, unlock window, erase, write, read.
// Assumes the flash array shares ref_clk and samples the strobes it is given.
`timescale 1ns/10ps
module ifpc_top #(
  parameter int unsigned PROG_CYCLES_P = ifpc_pkg::PROG_CYCLES, // Erase/write busy time
  parameter int unsigned UNLOCK_CYCLES_P = ifpc_pkg::UNLOCK_CYCLES, // Unlock window
  parameter int unsigned READ_CYCLES_P = ifpc_pkg::READ_CYCLES // Word read time
) (
  input wire logic ref_clk, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire logic regWr, // Register write strobe
  input wire logic regRd, // Register read strobe
  input wire logic [3:0] regIdx, // Register index
  input wire logic [7:0] regWrData, // Write byte
  output logic [7:0] regRdData, // Read byte, one cycle later
  output logic [ifpc_pkg::ADDR_W-1:0] arrayAddr, // Array word address
  output logic [ifpc_pkg::DATA_W-1:0] arrayWrData, // Array write word
  output logic arrayWrStb, // Program one word
  output logic arrayEraseStb, // Erase one page
  output logic arrayRdStb, // Read one word
  input wire logic [ifpc_pkg::DATA_W-1:0] arrayRdData, // Array read word
  output logic cpuHalt, // CPU stalled
  output logic chipReset // Whole-chip reset pulse
);
  import ifpc_pkg::*;

  // Sequencer states: idle, erase strobe, page stream, busy wait, word read
  typedef enum logic [2:0] {ST_IDLE, ST_ERASE, ST_STREAM, ST_PROG, ST_READ} ifpc_state_t;

  // Page base of an address
  function automatic logic [ADDR_W-1:0] pageBase(input logic [ADDR_W-1:0] a);
    pageBase = {a[ADDR_W-1:PAGE_W], {PAGE_W{1'b0}}};
  endfunction : pageBase

  // True on the last cycle of a count running from zero to lim-1
  function automatic logic timerDone(input logic [31:0] cnt, input int unsigned lim);
    timerDone = (cnt >= lim - 32'h0000_0001);
  endfunction : timerDone

  // Register state
  ifpc_state_t state_reg, state_next; // Sequencer state
  ifpc_ctrl_t ctrl_reg, ctrl_next; // Control/status byte
  logic [ADDR_W-1:0] addr_reg, addr_next; // Address pair
  logic [DATA_W-1:0] d0_reg, d0_next; // First data pair
  logic [DATA_W-1:0] d1_reg, d1_next; // Second data pair
  logic [DATA_W-1:0] d2_reg, d2_next; // Third data pair
  logic [DATA_W-1:0] d3_reg, d3_next; // Fourth data pair
  logic [7:0] rstPat_reg, rstPat_next; // Chip reset pattern
  logic clr_reg, clr_next; // Buffer-clear bit
  logic [DATA_W-1:0] buf_reg [BUF_WORDS]; // Page write buffer
  logic [DATA_W-1:0] buf_next [BUF_WORDS];
  logic [PAGE_W-1:0] idx_reg, idx_next; // Stream index
  // Counters are wide enough for the full busy time
  logic [31:0] opCnt_reg, opCnt_next; // Busy timer
  logic [31:0] unlCnt_reg, unlCnt_next; // Unlock timer
  logic opWrite_reg, opWrite_next; // Current op is write
  // Output flops
  logic [7:0] rdData_reg, rdData_next;
  logic [ADDR_W-1:0] aAddr_reg, aAddr_next;
  logic [DATA_W-1:0] aData_reg, aData_next;
  logic wrStb_reg, wrStb_next;
  logic erStb_reg, erStb_next;
  logic rdStb_reg, rdStb_next;
  logic halt_reg, halt_next;
  logic chipRst_reg, chipRst_next;
  // Helpers
  ifpc_ctrl_t wrCtrl; // Incoming control byte
  logic unlockOk; // Pattern matches
  logic enSet; // Hardware sets enabled

  // Incoming byte seen as a control word
  assign wrCtrl = ifpc_ctrl_t'(regWrData);
  // All three unlock words must match at once
  assign unlockOk = (d1_reg == UNLOCK_WORD1) && (d2_reg == UNLOCK_WORD2) && (d3_reg == UNLOCK_WORD3); // RULE_10

  // Next-state logic for all registers
  always_comb begin
    // Every register but the strobes, pulses and halt holds unless a branch below changes it
    state_next = state_reg;
    ctrl_next = ctrl_reg;
    addr_next = addr_reg;
    d0_next = d0_reg;
    d1_next = d1_reg;
    d2_next = d2_reg;
    d3_next = d3_reg;
    rstPat_next = rstPat_reg;
    clr_next = clr_reg;
    buf_next = buf_reg;
    idx_next = idx_reg;
    opCnt_next = opCnt_reg;
    unlCnt_next = unlCnt_reg;
    opWrite_next = opWrite_reg;
    rdData_next = rdData_reg;
    aAddr_next = aAddr_reg;
    aData_next = aData_reg;
    // Strobes and pulses default low
    wrStb_next = 1'b0;
    erStb_next = 1'b0;
    rdStb_next = 1'b0;
    chipRst_next = 1'b0;
    enSet = 1'b0;

    // Register read mux
    // Read data is registered and shows the cycle after the strobe
    if (regRd) begin
      case (regIdx)
        IDX_ADDR_LOW: rdData_next = addr_reg[7:0];
        IDX_ADDR_HIGH: rdData_next = {2'b00, addr_reg[ADDR_W-1:ADDR_HIGH_LSB]}; // RULE_01
        IDX_D0_LOW: rdData_next = d0_reg[7:0];
        IDX_D0_HIGH: rdData_next = d0_reg[15:8];
        IDX_D1_LOW: rdData_next = d1_reg[7:0];
        IDX_D1_HIGH: rdData_next = d1_reg[15:8];
        IDX_D2_LOW: rdData_next = d2_reg[7:0];
        IDX_D2_HIGH: rdData_next = d2_reg[15:8];
        IDX_D3_LOW: rdData_next = d3_reg[7:0];
        IDX_D3_HIGH: rdData_next = d3_reg[15:8];
        IDX_CTRL: rdData_next = ctrl_reg; // RULE_05
        IDX_RST_PAT: rdData_next = rstPat_reg;
        IDX_BUF_CLR: rdData_next = {7'h00, clr_reg};
        default: rdData_next = BYTE_RESET; // Unmapped reads zero
      endcase
    end

    // Unlock window timer
    if (ctrl_reg.trigger) begin
      // The pattern is judged only when the window closes
      if (timerDone(unlCnt_reg, UNLOCK_CYCLES_P)) begin
        ctrl_next.trigger = 1'b0; // RULE_08
        unlCnt_next = 32'h0000_0000;
        enSet = (ctrl_reg.mode == MODE_UNLOCK) && unlockOk; // RULE_10
      end else begin
        unlCnt_next = unlCnt_reg + 32'h0000_0001;
      end
    end

    // Buffer clear takes one cycle
    // A write setting the bit again in this cycle wins
    if (clr_reg) begin
      for (int i = 0; i < BUF_WORDS; i++) begin
        buf_next[i] = WORD_RESET; // RULE_19
      end
      clr_next = 1'b0; // RULE_19
    end

    // Register writes, only while the CPU runs
    if (regWr && state_reg == ST_IDLE) begin
      case (regIdx)
        IDX_ADDR_LOW: addr_next[7:0] = regWrData;
        IDX_ADDR_HIGH: addr_next[ADDR_W-1:ADDR_HIGH_LSB] = regWrData[5:0]; // RULE_01
        IDX_D0_LOW: d0_next[7:0] = regWrData; // RULE_02
        IDX_D0_HIGH: begin
          d0_next[15:8] = regWrData;
          // Locked: the address still steps and the high byte is kept, the buffer is not written
          if (ctrl_reg.enabled) begin
            buf_next[addr_reg[PAGE_W-1:0]] = {regWrData, d0_reg[7:0]}; // RULE_03
          end
          // The address freezes on the last word of the page
          if (addr_reg[PAGE_W-1:0] != PAGE_LAST) begin
            addr_next = addr_reg + 14'h0001; // RULE_03 RULE_20
          end
        end
        // Unlock pattern registers are plain storage
        IDX_D1_LOW: d1_next[7:0] = regWrData;
        IDX_D1_HIGH: d1_next[15:8] = regWrData;
        IDX_D2_LOW: d2_next[7:0] = regWrData;
        IDX_D2_HIGH: d2_next[15:8] = regWrData;
        IDX_D3_LOW: d3_next[7:0] = regWrData;
        IDX_D3_HIGH: d3_next[15:8] = regWrData;
        IDX_CTRL: begin
          // Mode and read-enable follow the written byte
          ctrl_next.mode = wrCtrl.mode; // RULE_06
          ctrl_next.rdEnable = wrCtrl.rdEnable; // RULE_13
          // Writing one to the enabled bit does nothing
          if (!wrCtrl.enabled) begin
            ctrl_next.enabled = 1'b0; // RULE_04
          end
          // A running window is never restarted
          if (wrCtrl.trigger && !ctrl_reg.trigger) begin
            ctrl_next.trigger = 1'b1; // RULE_08
            unlCnt_next = 32'h0000_0000;
          end
          if (wrCtrl.wrInit && ctrl_reg.enabled) begin
            // Locked device ignores the request
            if (wrCtrl.mode == MODE_ERASE) begin
              // One erase strobe at the page base, then wait
              ctrl_next.wrInit = 1'b1; // RULE_11 RULE_25
              state_next = ST_ERASE;
              opWrite_next = 1'b0;
              erStb_next = 1'b1;
              aAddr_next = pageBase(addr_reg); // RULE_26
              opCnt_next = 32'h0000_0000;
            end else if (wrCtrl.mode == MODE_WRITE) begin
              // Stream the whole buffer, then wait
              ctrl_next.wrInit = 1'b1; // RULE_11 RULE_25
              state_next = ST_STREAM;
              opWrite_next = 1'b1;
              idx_next = {PAGE_W{1'b0}};
            end
          end else if (wrCtrl.rdInit && wrCtrl.rdEnable && wrCtrl.mode == MODE_READ) begin
            // Read-enable and read mode must come in the same byte
            ctrl_next.rdInit = 1'b1; // RULE_13 RULE_14
            state_next = ST_READ;
            rdStb_next = 1'b1;
            aAddr_next = addr_reg;
            opCnt_next = 32'h0000_0000;
          end
        end
        IDX_RST_PAT: begin
          // Any value is kept; only the key pulses reset
          rstPat_next = regWrData;
          chipRst_next = (regWrData == CHIP_RESET_KEY); // RULE_18
        end
        IDX_BUF_CLR: begin
          // Only bit zero is implemented
          if (regWrData[BUF_CLR_BIT]) begin
            clr_next = 1'b1; // RULE_19
          end
        end
        default: ; // Unmapped writes ignored
      endcase
    end

    // Hardware set of enabled wins over a same-cycle clear
    if (enSet) begin
      ctrl_next.enabled = 1'b1; // RULE_04 RULE_05
    end

    // Sequencer
    case (state_reg)
      ST_IDLE: ;
      ST_ERASE: begin
        // Gives the erase strobe its single cycle
        state_next = ST_PROG; // Erase strobe already issued
      end
      ST_STREAM: begin
        // Hand the whole page to the array, one word per cycle
        wrStb_next = 1'b1;
        aAddr_next = {addr_reg[ADDR_W-1:PAGE_W], idx_reg};
        aData_next = buf_reg[idx_reg];
        // The last word hands over to the busy wait
        if (idx_reg == PAGE_LAST) begin
          state_next = ST_PROG;
          opCnt_next = 32'h0000_0000;
        end else begin
          idx_next = idx_reg + 6'h01;
        end
      end
      ST_PROG: begin
        // Array busy time; the CPU stays halted
        if (timerDone(opCnt_reg, PROG_CYCLES_P)) begin
          ctrl_next.wrInit = 1'b0; // RULE_11 RULE_12
          state_next = ST_IDLE;
          // Written data is dropped so the next page starts clean
          if (opWrite_reg) begin
            for (int i = 0; i < BUF_WORDS; i++) begin
              buf_next[i] = WORD_RESET; // RULE_21
            end
          end
        end else begin
          opCnt_next = opCnt_reg + 32'h0000_0001;
        end
      end
      ST_READ: begin
        // Data is taken on the last cycle of the access time
        if (timerDone(opCnt_reg, READ_CYCLES_P)) begin
          d0_next = arrayRdData; // RULE_14
          ctrl_next.rdInit = 1'b0; // RULE_14
          state_next = ST_IDLE;
        end else begin
          opCnt_next = opCnt_reg + 32'h0000_0001;
        end
      end
      // An unknown state falls back to idle
      default: state_next = ST_IDLE;
    endcase

    // Halt follows the next state so both flops agree
    halt_next = (state_next != ST_IDLE); // RULE_11 RULE_14
  end

  // Register everything
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      ctrl_reg <= ifpc_ctrl_t'(BYTE_RESET);
      addr_reg <= ADDR_RESET;
      d0_reg <= WORD_RESET;
      d1_reg <= WORD_RESET;
      d2_reg <= WORD_RESET;
      d3_reg <= WORD_RESET;
      rstPat_reg <= BYTE_RESET;
      clr_reg <= 1'b0;
      // Every buffer word clears at once
      for (int i = 0; i < BUF_WORDS; i++) begin
        buf_reg[i] <= WORD_RESET;
      end
      idx_reg <= {PAGE_W{1'b0}};
      opCnt_reg <= 32'h0000_0000;
      unlCnt_reg <= 32'h0000_0000;
      opWrite_reg <= 1'b0;
      rdData_reg <= BYTE_RESET;
      aAddr_reg <= ADDR_RESET;
      aData_reg <= WORD_RESET;
      wrStb_reg <= 1'b0;
      erStb_reg <= 1'b0;
      rdStb_reg <= 1'b0;
      halt_reg <= 1'b0;
      chipRst_reg <= 1'b0;
    end else begin
      // Normal operation takes the next values
      state_reg <= state_next;
      ctrl_reg <= ctrl_next;
      addr_reg <= addr_next;
      d0_reg <= d0_next;
      d1_reg <= d1_next;
      d2_reg <= d2_next;
      d3_reg <= d3_next;
      rstPat_reg <= rstPat_next;
      clr_reg <= clr_next;
      buf_reg <= buf_next;
      idx_reg <= idx_next;
      opCnt_reg <= opCnt_next;
      unlCnt_reg <= unlCnt_next;
      opWrite_reg <= opWrite_next;
      rdData_reg <= rdData_next;
      aAddr_reg <= aAddr_next;
      aData_reg <= aData_next;
      wrStb_reg <= wrStb_next;
      erStb_reg <= erStb_next;
      rdStb_reg <= rdStb_next;
      halt_reg <= halt_next;
      chipRst_reg <= chipRst_next;
    end
  end

  // Outputs straight from flops
  // Nothing combinational reaches a port
  assign regRdData = rdData_reg;
  assign arrayAddr = aAddr_reg;
  assign arrayWrData = aData_reg;
  assign arrayWrStb = wrStb_reg;
  assign arrayEraseStb = erStb_reg;
  assign arrayRdStb = rdStb_reg;
  assign cpuHalt = halt_reg;
  assign chipReset = chipRst_reg;
endmodule : ifpc_top

// [sim/ifpc_top_sva.sv]
// Port checker for the flash programming controller.
// Assumes it is bound into ifpc_top and sees only that module's ports.
`timescale 1ns/10ps
module ifpc_top_sva #(
  parameter int unsigned PROG_CYCLES_P = 20, // Erase/write busy time
  parameter int unsigned UNLOCK_CYCLES_P = 16, // Unlock window
  parameter int unsigned READ_CYCLES_P = 4 // Word read time
) (
  input wire logic ref_clk, // System clock
  input wire logic rst_b, // Reset, active low
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  input wire logic [3:0] regIdx, // Register index
  input wire logic [7:0] regWrData, // Write byte
  input wire logic [7:0] regRdData, // Read byte
  input wire logic [ifpc_pkg::ADDR_W-1:0] arrayAddr, // Array address
  input wire logic [ifpc_pkg::DATA_W-1:0] arrayWrData, // Array write word
  input wire logic arrayWrStb, // Program strobe
  input wire logic arrayEraseStb, // Erase strobe
  input wire logic arrayRdStb, // Read strobe
  input wire logic [ifpc_pkg::DATA_W-1:0] arrayRdData, // Array read word
  input wire logic cpuHalt, // CPU stalled
  input wire logic chipReset // Chip reset pulse
);
  import ifpc_pkg::*;
  localparam int RD_MAX = READ_CYCLES_P + 1; // Longest read halt
  logic [31:0] haltCnt_reg; // Cycles spent halted
  logic [31:0] haltCnt_next; // Next halt count
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Count consecutive halted cycles
  always_comb begin
    haltCnt_next = cpuHalt ? haltCnt_reg + 32'h0000_0001 : 32'h0000_0000;
  end
  // Register the halt count
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      haltCnt_reg <= 32'h0000_0000;
    end else begin
      haltCnt_reg <= haltCnt_next;
    end
  end
  AST_KEY_PULSE: assert property (regWr && !cpuHalt && regIdx == IDX_RST_PAT && regWrData == CHIP_RESET_KEY
    |=> chipReset) else $error("no chip reset after key write");
  AST_KEY_ONLY: assert property (chipReset |-> $past(regWr) && $past(regIdx) == IDX_RST_PAT
    && $past(regWrData) == CHIP_RESET_KEY) else $error("chip reset without key");
  AST_ERASE_PAGE: assert property (arrayEraseStb |-> arrayAddr[5:0] == 6'h00 && cpuHalt)
    else $error("erase not page aligned or not halted");
  AST_ERASE_ONE: assert property (arrayEraseStb |=> !arrayEraseStb) else $error("erase strobe too long");
  AST_WR_START: assert property ($rose(arrayWrStb) |-> arrayAddr[5:0] == 6'h00 && cpuHalt)
    else $error("write burst start wrong");
  AST_WR_BURST: assert property ($rose(arrayWrStb) |-> arrayWrStb[*8]) else $error("write burst broken");
  AST_WR_STEP: assert property (arrayWrStb && $past(arrayWrStb) |-> arrayAddr == $past(arrayAddr) + 14'h0001)
    else $error("write address not stepping");
  AST_RD_HALT: assert property ($rose(arrayRdStb) |-> cpuHalt ##[1:RD_MAX] !cpuHalt)
    else $error("read halt wrong");
  AST_RD_ONE: assert property (arrayRdStb |=> !arrayRdStb) else $error("read strobe too long");
  AST_HALT_MAX: assert property (haltCnt_reg <= PROG_CYCLES_P + 70) else $error("halt too long");
  COV_ERASE: cover property (arrayEraseStb);
  COV_WRITE: cover property ($fell(arrayWrStb));
  COV_READ: cover property (arrayRdStb);
  COV_RESET: cover property (chipReset);
endmodule : ifpc_top_sva
bind ifpc_top ifpc_top_sva #(.PROG_CYCLES_P(PROG_CYCLES_P), .UNLOCK_CYCLES_P(UNLOCK_CYCLES_P),
  .READ_CYCLES_P(READ_CYCLES_P)) uSva (.ref_clk(ref_clk), .rst_b(rst_b), .regWr(regWr), .regRd(regRd),
  .regIdx(regIdx), .regWrData(regWrData), .regRdData(regRdData), .arrayAddr(arrayAddr),
  .arrayWrData(arrayWrData), .arrayWrStb(arrayWrStb), .arrayEraseStb(arrayEraseStb), .arrayRdStb(arrayRdStb),
  .arrayRdData(arrayRdData), .cpuHalt(cpuHalt), .chipReset(chipReset));

// [sim/ifpc_flash_model.sv]
// Behavioural flash array on the far side of the controller.
// Assumes strobes and address come from ifpc_top on the same clock.
`timescale 1ns/10ps
module ifpc_flash_model #(
  parameter int unsigned READ_CYCLES_P = 4 // Read access time
) (
  input wire logic ref_clk, // System clock
  input wire logic [ifpc_pkg::ADDR_W-1:0] arrayAddr, // Word address
  input wire logic [ifpc_pkg::DATA_W-1:0] arrayWrData, // Program word
  input wire logic arrayWrStb, // Program strobe
  input wire logic arrayEraseStb, // Erase strobe
  input wire logic arrayRdStb, // Read strobe
  output logic [ifpc_pkg::DATA_W-1:0] arrayRdData // Read word
);
  import ifpc_pkg::*;
  logic [DATA_W-1:0] mem [int]; // Sparse array, unwritten words read ffff
  int holdCnt = 0; // Cycles the read word stays valid
  initial arrayRdData = 16'h5a5a;
  // Program, erase and read; outside a read the data toggles
  always @(posedge ref_clk) begin
    if (arrayWrStb) begin
      mem[int'(arrayAddr)] = arrayWrData;
    end
    if (arrayEraseStb) begin
      for (int k = 0; k < BUF_WORDS; k++) begin
        mem[int'({arrayAddr[13:6], 6'(k)})] = WORD_RESET;
      end
    end
    if (arrayRdStb) begin
      arrayRdData <= mem.exists(int'(arrayAddr)) ? mem[int'(arrayAddr)] : 16'hffff;
      holdCnt <= READ_CYCLES_P;
    end else if (holdCnt > 0) begin
      holdCnt <= holdCnt - 1;
    end else begin
      arrayRdData <= ~arrayRdData;
    end
  end
endmodule : ifpc_flash_model

// [sim/iap_flash_program_control_test.sv]
// Self-checking bench for the flash programming controller.
// Assumes ifpc_top, its checker and the flash array model are compiled first.
`timescale 1ns/10ps
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin errCount++; $display("BAD %0t got %h want %h", $time, g, e); end end
module iap_flash_program_control_test;
  import ifpc_pkg::*;
  typedef struct packed {logic [3:0] idx; logic [7:0] wv; logic [7:0] ev;} ifpc_row_t;
  logic ref_clk = 1'b0; // System clock
  logic rst_b = 1'b0; // Reset, active low
  logic regWr = 1'b0; // Write strobe
  logic regRd = 1'b0; // Read strobe
  logic [3:0] regIdx = 4'h0; // Register index
  logic [7:0] regWrData = 8'h00; // Write byte
  logic [7:0] regRdData; // Read byte
  logic [ADDR_W-1:0] arrayAddr; // Array address
  logic [DATA_W-1:0] arrayWrData; // Array write word
  logic [DATA_W-1:0] arrayRdData; // Array read word
  logic arrayWrStb, arrayEraseStb, arrayRdStb, cpuHalt, chipReset; // Design outputs
  int errCount = 0; // Mismatches
  int nTests = 0; // Comparisons
  int cycles = 0; // Elapsed clock cycles
  logic [7:0] pat [6] = '{8'h00, 8'h04, 8'h0d, 8'h09, 8'hc3, 8'h40}; // Unlock bytes, low then high
  // Register rows: index, byte written, byte read back
  ifpc_row_t rows [9] = '{'{IDX_ADDR_HIGH, 8'hff, 8'h3f}, '{IDX_ADDR_LOW, 8'h5a, 8'h5a}, '{IDX_D0_LOW, 8'h12, 8'h12},
    '{IDX_D1_HIGH, 8'h3c, 8'h3c}, '{IDX_D3_LOW, 8'ha5, 8'ha5}, '{IDX_CTRL, 8'ha0, 8'h20},
    '{IDX_RST_PAT, 8'h54, 8'h54}, '{IDX_BUF_CLR, 8'hfe, 8'h00}, '{4'hd, 8'h77, 8'h00}};
  ifpc_top #(.PROG_CYCLES_P(20), .UNLOCK_CYCLES_P(32), .READ_CYCLES_P(4)) DUT (.ref_clk(ref_clk), .rst_b(rst_b),
    .regWr(regWr), .regRd(regRd), .regIdx(regIdx), .regWrData(regWrData), .regRdData(regRdData),
    .arrayAddr(arrayAddr), .arrayWrData(arrayWrData), .arrayWrStb(arrayWrStb), .arrayEraseStb(arrayEraseStb),
    .arrayRdStb(arrayRdStb), .arrayRdData(arrayRdData), .cpuHalt(cpuHalt), .chipReset(chipReset));
  ifpc_flash_model #(.READ_CYCLES_P(4)) uFlash (.ref_clk(ref_clk), .arrayAddr(arrayAddr),
    .arrayWrData(arrayWrData), .arrayWrStb(arrayWrStb), .arrayEraseStb(arrayEraseStb),
    .arrayRdStb(arrayRdStb), .arrayRdData(arrayRdData));
  // Clock
  always #2 ref_clk = ~ref_clk;
  // Cut a hang short
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errCount++;
      finishTest();
    end
  end
  // One register write
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    @(posedge ref_clk) #1;
    regWr = 1'b1;
    regIdx = i;
    regWrData = d;
    @(posedge ref_clk) #1;
    regWr = 1'b0;
  endtask : wr
  // One register read, compared with the expected byte
  task automatic rd(input logic [3:0] i, input logic [7:0] e);
    @(posedge ref_clk) #1;
    regRd = 1'b1;
    regIdx = i;
    @(posedge ref_clk) #1;
    regRd = 1'b0;
    `CHK(regRdData, e)
  endtask : rd
  // Wait, bounded, until the CPU is released
  task automatic waitIdle();
    int n = 0;
    repeat (2) @(posedge ref_clk);
    #1;
    while (cpuHalt !== 1'b0 && n < 500) begin
      @(posedge ref_clk) #1;
      n++;
    end
    `CHK(cpuHalt, 1'b0)
  endtask : waitIdle
  // Read one array word through the data pair
  task automatic rdWord(input logic [13:0] a, input logic [15:0] e);
    wr(IDX_ADDR_HIGH, {2'b00, a[13:8]});
    wr(IDX_ADDR_LOW, a[7:0]);
    wr(IDX_CTRL, 8'hb3);
    waitIdle();
    rd(IDX_D0_LOW, e[7:0]);
    rd(IDX_D0_HIGH, e[15:8]);
  endtask : rdWord
  // Unlock attempt; last byte chosen by caller
  task automatic unlock(input logic [7:0] last, input logic [7:0] e);
    wr(IDX_CTRL, 8'h68);
    rd(IDX_CTRL, 8'h68);
    for (int i = 0; i < 6; i++) begin
      wr(IDX_D1_LOW + 4'(i), (i == 5) ? last : pat[i]);
    end
    repeat (40) @(posedge ref_clk);
    rd(IDX_CTRL, e);
  endtask : unlock
  // Counts and verdict
  task automatic finishTest();
    $display("Counts: %0d checks, %0d mismatches", nTests, errCount);
    if (errCount == 0 && nTests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finishTest
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    foreach (rows[r]) begin
      rd(rows[r].idx, 8'h00);
      wr(rows[r].idx, rows[r].wv);
      rd(rows[r].idx, rows[r].ev);
    end
    rd(IDX_ADDR_LOW, 8'h5a);
    $display("register table done");
    wr(IDX_ADDR_LOW, 8'h3e);
    wr(IDX_D0_HIGH, 8'h00);
    rd(IDX_ADDR_LOW, 8'h3f);
    wr(IDX_D0_HIGH, 8'h00);
    rd(IDX_ADDR_LOW, 8'h3f);
    rd(IDX_ADDR_HIGH, 8'h3f);
    $display("address step done");
    unlock(8'h41, 8'h60);
    unlock(8'h40, 8'he0);
    $display("unlock done");
    wr(IDX_ADDR_HIGH, 8'h00);
    wr(IDX_ADDR_LOW, 8'h85);
    wr(IDX_CTRL, 8'h94);
    waitIdle();
    rd(IDX_CTRL, 8'h90);
    rdWord(14'h0080, 16'h0000);
    rdWord(14'h00c0, 16'hffff);
    $display("erase done");
    wr(IDX_ADDR_LOW, 8'h82);
    wr(IDX_D0_HIGH, 8'h77);
    wr(IDX_BUF_CLR, 8'h01);
    rd(IDX_BUF_CLR, 8'h00);
    wr(IDX_ADDR_LOW, 8'h80);
    wr(IDX_D0_LOW, 8'h34);
    wr(IDX_D0_HIGH, 8'h12);
    wr(IDX_D0_LOW, 8'hef);
    wr(IDX_D0_HIGH, 8'hbe);
    rd(IDX_ADDR_LOW, 8'h82);
    wr(IDX_CTRL, 8'h84);
    waitIdle();
    rd(IDX_CTRL, 8'h80);
    rdWord(14'h0080, 16'h1234);
    rdWord(14'h0081, 16'hbeef);
    rdWord(14'h0082, 16'h0000);
    wr(IDX_CTRL, 8'h84);
    waitIdle();
    rdWord(14'h0080, 16'h0000);
    $display("write done");
    wr(IDX_CTRL, 8'h00);
    wr(IDX_CTRL, 8'h84);
    #1;
    `CHK(cpuHalt, 1'b0)
    rd(IDX_CTRL, 8'h00);
    wr(IDX_CTRL, 8'h31);
    #1;
    `CHK(cpuHalt, 1'b0)
    rd(IDX_CTRL, 8'h30);
    $display("lock done");
    wr(IDX_RST_PAT, 8'h55);
    `CHK(chipReset, 1'b1)
    @(posedge ref_clk) #1;
    `CHK(chipReset, 1'b0)
    rst_b = 1'b0;
    @(posedge ref_clk) #1;
    rst_b = 1'b1;
    rd(IDX_RST_PAT, 8'h00);
    rd(IDX_CTRL, 8'h00);
    $display("reset done");
    finishTest();
  end
endmodule : iap_flash_program_control_test
